// >>> idc_dac_ctrl.sv
// idc_dac_ctrl: two-channel current dac register and update control
// assumes core sfr bus: address, page, write/read strobes synchronous to SYS_CLK_IN
`timescale 1ns/1ns
`default_nettype none
module idc_dac_ctrl
  import idc_pkg::*;
(
  input  wire logic       SYS_CLK_IN,
  input  wire logic       RST_N_IN,
  input  wire logic       POR_N_IN,
  input  wire logic [7:0] SFR_ADDR_IN,
  input  wire logic [3:0] SFR_PAGE_IN,
  input  wire logic       SFR_WR_IN,
  input  wire logic       SFR_RD_IN,
  input  wire logic [7:0] SFR_WDATA_IN,
  input  wire logic       TIMER0_OVF_IN,
  input  wire logic       TIMER1_OVF_IN,
  input  wire logic       TIMER2_OVF_IN,
  input  wire logic       TIMER3_OVF_IN,
  input  wire logic       TIMER5_OVF_IN,
  input  wire logic       EXTERNAL_CONVERSION_TRIGGER_IN,
  output logic      [7:0] SFR_RDATA_OUT,
  output logic            SFR_HIT_OUT,
  output logic      [9:0] DAC0_CODE_OUT,
  output logic      [9:0] DAC1_CODE_OUT,
  output logic            DAC0_ENABLE_OUT,
  output logic            DAC1_ENABLE_OUT,
  output logic      [1:0] DAC0_FULLSCALE_OUT,
  output logic      [1:0] DAC1_FULLSCALE_OUT
);

  idc_chan_if ch_if[2] ();
  logic [3:0] ovf_sel [2];
  logic [7:0] rdata;
  logic       hit;

  assign ovf_sel[0] = {TIMER3_OVF_IN, TIMER2_OVF_IN, TIMER1_OVF_IN, TIMER0_OVF_IN};
  assign ovf_sel[1] = {TIMER3_OVF_IN, TIMER2_OVF_IN, TIMER5_OVF_IN, TIMER0_OVF_IN};

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic page_hit(input logic [3:0] page, input int ch);
    page_hit = (ch == 0) ? (page == IDC_PAGE_CH0) : (page == IDC_PAGE_CH1);
  endfunction : page_hit

  logic [7:0] rd_arr [2];
  logic       hit_arr [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      logic sel;
      assign sel = page_hit(SFR_PAGE_IN, g);
      assign ch_if[g].wr_ctl  = SFR_WR_IN && sel && SFR_ADDR_IN == IDC_ADDR_CONTROL;
      assign ch_if[g].wr_high = SFR_WR_IN && sel && SFR_ADDR_IN == IDC_ADDR_WORD_HIGH;
      assign ch_if[g].wr_low  = SFR_WR_IN && sel && SFR_ADDR_IN == IDC_ADDR_WORD_LOW;
      assign ch_if[g].wdata   = SFR_WDATA_IN;

      always_comb
      begin
        hit_arr[g] = sel;
        unique case (SFR_ADDR_IN)
          IDC_ADDR_CONTROL:   rd_arr[g] = ch_if[g].ctl_rd;
          IDC_ADDR_WORD_HIGH: rd_arr[g] = ch_if[g].high_rd;
          IDC_ADDR_WORD_LOW:  rd_arr[g] = ch_if[g].low_rd;
          default:
          begin
            rd_arr[g]  = 8'h00;
            hit_arr[g] = 1'b0;
          end
        endcase
      end

      idc_channel u_chan (
        .clk_in       (SYS_CLK_IN),
        .rst_n_in     (RST_N_IN),
        .por_n_in     (POR_N_IN),
        .timer_ovf_in (ovf_sel[g]),
        .trig_in      (EXTERNAL_CONVERSION_TRIGGER_IN),
        .bus          (ch_if[g])
      );
    end
  endgenerate

  always_comb
  begin
    rdata = 8'h00;
    hit   = 1'b0;
    if (hit_arr[0])
    begin
      rdata = rd_arr[0];
      hit   = 1'b1;
    end
    else if (hit_arr[1])
    begin
      rdata = rd_arr[1];
      hit   = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      SFR_RDATA_OUT <= 8'h00;
      SFR_HIT_OUT   <= 1'b0;
    end
    else
    begin
      SFR_RDATA_OUT <= SFR_RD_IN ? rdata : 8'h00;
      SFR_HIT_OUT   <= SFR_RD_IN && hit;
    end
  end

  // one-edge copy of the whole word, fed from channel latches
  always_ff @(posedge SYS_CLK_IN)
  begin
    DAC0_CODE_OUT      <= ch_if[0].latch;
    DAC1_CODE_OUT      <= ch_if[1].latch;
    DAC0_ENABLE_OUT    <= ch_if[0].enable;
    DAC1_ENABLE_OUT    <= ch_if[1].enable;
    DAC0_FULLSCALE_OUT <= idc_fs_decode(ch_if[0].fs_sel);
    DAC1_FULLSCALE_OUT <= idc_fs_decode(ch_if[1].fs_sel);
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // channel 1 control write and any mapped low read
  sequence s_ch1_ctl_write;
    SFR_WR_IN && SFR_PAGE_IN == IDC_PAGE_CH1 && SFR_ADDR_IN == IDC_ADDR_CONTROL;
  endsequence

  sequence s_low_read;
    SFR_RD_IN && hit && SFR_ADDR_IN == IDC_ADDR_WORD_LOW;
  endsequence

  property p_unmapped_zero;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (SFR_RD_IN && !hit) |=> SFR_RDATA_OUT == 8'h00 && !SFR_HIT_OUT;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read nonzero");

  // no strobe, read bus rests at zero next cycle
  property p_idle_read_zero;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    !SFR_RD_IN |=> SFR_RDATA_OUT == 8'h00 && !SFR_HIT_OUT;
  endproperty
  a_idle_read_zero: assert property (p_idle_read_zero)
    else $error("read bus not idle");

  property p_low_read_unused;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    s_low_read |=> SFR_HIT_OUT && SFR_RDATA_OUT[5:0] == 6'h00;
  endproperty
  a_low_read_unused: assert property (p_low_read_unused)
    else $error("low read unused bits set");

  property p_ctl_reserved_zero;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (SFR_RD_IN && hit && SFR_ADDR_IN == IDC_ADDR_CONTROL)
      |=> SFR_HIT_OUT && !SFR_RDATA_OUT[IDC_BIT_RESERVED];
  endproperty
  a_ctl_reserved_zero: assert property (p_ctl_reserved_zero)
    else $error("reserved control bit set");

  property p_high_read_ch0;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    (SFR_RD_IN && SFR_PAGE_IN == IDC_PAGE_CH0 && SFR_ADDR_IN == IDC_ADDR_WORD_HIGH)
      |=> SFR_HIT_OUT && SFR_RDATA_OUT == $past(ch_if[0].high_rd);
  endproperty
  a_high_read_ch0: assert property (p_high_read_ch0)
    else $error("channel 0 high read wrong");

  // enable bit reaches the pin two edges after the write
  property p_ch1_enable_write;
    @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
    s_ch1_ctl_write |-> ##2 DAC1_ENABLE_OUT == $past(SFR_WDATA_IN[IDC_BIT_ENABLE], 2);
  endproperty
  a_ch1_enable_write: assert property (p_ch1_enable_write)
    else $error("channel 1 enable not applied");

  property p_fullscale_map;
    @(posedge SYS_CLK_IN) disable iff (!POR_N_IN)
    DAC1_FULLSCALE_OUT ==
      ($past(ch_if[1].fs_sel[1]) ? 2'h2 : {1'b0, $past(ch_if[1].fs_sel[0])});
  endproperty
  a_fullscale_map: assert property (p_fullscale_map)
    else $error("full-scale decode wrong");

  // whole word moves to the pins in one edge
  property p_code_follows;
    @(posedge SYS_CLK_IN) disable iff (!POR_N_IN)
    DAC0_CODE_OUT == $past(ch_if[0].latch) && DAC1_CODE_OUT == $past(ch_if[1].latch);
  endproperty
  a_code_follows: assert property (p_code_follows)
    else $error("code output not one word");

endmodule : idc_dac_ctrl
`default_nettype wire

// >>> idc_pkg.sv
// idc_pkg: register map, field layout, reset values and mode codes of the two-channel current dac
// assumes an 8-bit special function register bus with a page selector from the core
package idc_pkg;

  // ----------------------------------------------------------------
  // register addresses and pages
  // ----------------------------------------------------------------
  localparam logic [7:0] IDC_ADDR_CONTROL   = 8'hB9;
  localparam logic [7:0] IDC_ADDR_WORD_HIGH = 8'h97;
  localparam logic [7:0] IDC_ADDR_WORD_LOW  = 8'h96;
  localparam logic [3:0] IDC_PAGE_CH0       = 4'h0;
  localparam logic [3:0] IDC_PAGE_CH1       = 4'hF;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int IDC_BIT_ENABLE   = 7;
  localparam int IDC_SRC_MSB      = 6;
  localparam int IDC_SRC_LSB      = 4;
  localparam int IDC_BIT_RESERVED = 3;
  localparam int IDC_BIT_PERSIST  = 2;
  localparam int IDC_FS_MSB       = 1;
  localparam int IDC_FS_LSB       = 0;
  localparam int IDC_LOW_MSB      = 7;
  localparam int IDC_LOW_LSB      = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] IDC_SRC_RESET   = 3'h7;
  localparam logic [1:0] IDC_FS_RESET    = 2'h2;
  localparam logic [7:0] IDC_WORD_RESET  = 8'h00;
  localparam logic [9:0] IDC_LATCH_RESET = 10'h000;

  // ----------------------------------------------------------------
  // update source codes and full-scale selects
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IDC_SRC_TIMER0  = 3'h0,
    IDC_SRC_TIMERB  = 3'h1,
    IDC_SRC_TIMER2  = 3'h2,
    IDC_SRC_TIMER3  = 3'h3,
    IDC_SRC_RISE    = 3'h4,
    IDC_SRC_FALL    = 3'h5,
    IDC_SRC_ANY     = 3'h6,
    IDC_SRC_HIGHWR  = 3'h7
  } idc_src_t;

  typedef enum logic [1:0] {
    IDC_FS_HALF_MA = 2'h0,
    IDC_FS_ONE_MA  = 2'h1,
    IDC_FS_TWO_MA  = 2'h2
  } idc_fs_t;

  // 1x decodes to 2 mA, low bit ignored
  function automatic idc_fs_t idc_fs_decode(input logic [1:0] code);
    idc_fs_decode = code[1] ? IDC_FS_TWO_MA : (code[0] ? IDC_FS_ONE_MA : IDC_FS_HALF_MA);
  endfunction : idc_fs_decode

endpackage : idc_pkg

// >>> idc_chan_if.sv
// idc_chan_if: per-channel bundle between the register decode and a channel
// assumes one system clock domain
`timescale 1ns/1ns
`default_nettype none
interface idc_chan_if;
  logic       wr_ctl;
  logic       wr_high;
  logic       wr_low;
  logic [7:0] wdata;
  logic [7:0] ctl_rd;
  logic [7:0] high_rd;
  logic [7:0] low_rd;
  logic [9:0] latch;
  logic       enable;
  logic [1:0] fs_sel;

  modport top (output wr_ctl, wr_high, wr_low, wdata,
               input ctl_rd, high_rd, low_rd, latch, enable, fs_sel);
  modport chan (input wr_ctl, wr_high, wr_low, wdata,
                output ctl_rd, high_rd, low_rd, latch, enable, fs_sel);
endinterface : idc_chan_if
`default_nettype wire

// >>> idc_channel.sv
// idc_channel: one current dac channel, registers, update trigger and output latch
// assumes trigger inputs are one-cycle pulses/levels synchronous to the system clock
`timescale 1ns/1ns
`default_nettype none
module idc_channel
  import idc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic por_n_in,
  input  wire logic [3:0] timer_ovf_in,
  input  wire logic trig_in,
  idc_chan_if.chan  bus
);

  logic       enable_reg;
  logic [2:0] src_reg;
  logic       persist_reg;
  logic [1:0] fs_reg;
  logic [7:0] high_reg;
  logic [1:0] low_reg;
  logic [9:0] latch_reg;
  logic       trig_d_reg;
  logic       load;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!por_n_in)
    begin
      enable_reg <= 1'b0;
      src_reg    <= IDC_SRC_RESET;
      fs_reg     <= IDC_FS_RESET;
    end
    else if (!rst_n_in)
    begin
      if (!persist_reg)
        enable_reg <= 1'b0;
      src_reg <= IDC_SRC_RESET;
      fs_reg  <= IDC_FS_RESET;
    end
    else if (bus.wr_ctl)
    begin
      enable_reg <= bus.wdata[IDC_BIT_ENABLE];
      src_reg    <= bus.wdata[IDC_SRC_MSB:IDC_SRC_LSB];
      fs_reg     <= bus.wdata[IDC_FS_MSB:IDC_FS_LSB];
    end
  end

  // persistence cleared by power-on or a control write, never by system reset
  always_ff @(posedge clk_in)
  begin
    if (!por_n_in)
      persist_reg <= 1'b0;
    else if (rst_n_in && bus.wr_ctl)
      persist_reg <= bus.wdata[IDC_BIT_PERSIST];
  end

  // ----------------------------------------------------------------
  // data holding registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (!por_n_in || (!rst_n_in && !persist_reg))
    begin
      high_reg <= IDC_WORD_RESET;
      low_reg  <= 2'b00;
    end
    else if (rst_n_in)
    begin
      if (bus.wr_high)
        high_reg <= bus.wdata;
      if (bus.wr_low)
        low_reg <= bus.wdata[IDC_LOW_MSB:IDC_LOW_LSB];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      trig_d_reg <= 1'b0;
    else
      trig_d_reg <= trig_in;
  end

  // ----------------------------------------------------------------
  // update select
  // ----------------------------------------------------------------
  always_comb
  begin
    load = 1'b0;
    unique case (idc_src_t'(src_reg))
      IDC_SRC_TIMER0: load = timer_ovf_in[0];
      IDC_SRC_TIMERB: load = timer_ovf_in[1];
      IDC_SRC_TIMER2: load = timer_ovf_in[2];
      IDC_SRC_TIMER3: load = timer_ovf_in[3];
      IDC_SRC_RISE:   load = trig_in & ~trig_d_reg;
      IDC_SRC_FALL:   load = ~trig_in & trig_d_reg;
      IDC_SRC_ANY:    load = trig_in ^ trig_d_reg;
      IDC_SRC_HIGHWR: load = 1'b0;
    endcase
  end

  // whole word in one edge; with the high-write source, a high write loads the new high byte directly
  always_ff @(posedge clk_in)
  begin
    if (!por_n_in || (!rst_n_in && !persist_reg))
      latch_reg <= IDC_LATCH_RESET;
    else if (rst_n_in && src_reg == IDC_SRC_HIGHWR && bus.wr_high)
      latch_reg <= {bus.wdata, low_reg};
    else if (rst_n_in && load)
      latch_reg <= {high_reg, low_reg};
  end

  assign bus.ctl_rd  = {enable_reg, src_reg, 1'b0, persist_reg, fs_reg};
  assign bus.high_rd = high_reg;
  assign bus.low_rd  = {low_reg, 6'h00};
  assign bus.latch   = latch_reg;
  assign bus.enable  = enable_reg;
  assign bus.fs_sel  = fs_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_high_write_load;
    @(posedge clk_in) disable iff (!rst_n_in || !por_n_in)
    (src_reg == IDC_SRC_HIGHWR && bus.wr_high) |=> latch_reg == $past({bus.wdata, low_reg});
  endproperty
  a_high_write_load: assert property (p_high_write_load)
    else $error("high write no load");

  property p_hold_no_trigger;
    @(posedge clk_in) disable iff (!rst_n_in || !por_n_in)
    (src_reg != IDC_SRC_HIGHWR && !load) |=> $stable(latch_reg);
  endproperty
  a_hold_no_trigger: assert property (p_hold_no_trigger)
    else $error("latch moved untriggered");

  property p_rise_load;
    @(posedge clk_in) disable iff (!rst_n_in || !por_n_in)
    (src_reg == IDC_SRC_RISE && trig_in && !trig_d_reg) |=> latch_reg == $past({high_reg, low_reg});
  endproperty
  a_rise_load: assert property (p_rise_load)
    else $error("rising edge no load");

  property p_persist_keeps;
    @(posedge clk_in) disable iff (!por_n_in)
    (!rst_n_in && persist_reg && enable_reg) |=> enable_reg;
  endproperty
  a_persist_keeps: assert property (p_persist_keeps)
    else $error("persist lost enable");

  property p_plain_reset_off;
    @(posedge clk_in)
    (!rst_n_in && !persist_reg) |=> !enable_reg && fs_reg == IDC_FS_RESET;
  endproperty
  a_plain_reset_off: assert property (p_plain_reset_off)
    else $error("reset left enabled");

  // only bits 7..6 of a low write are kept, the rest read zero
  property p_low_reads_zero;
    @(posedge clk_in) disable iff (!rst_n_in || !por_n_in)
    bus.wr_low |=> bus.low_rd == {$past(bus.wdata[IDC_LOW_MSB:IDC_LOW_LSB]), 6'h00};
  endproperty
  a_low_reads_zero: assert property (p_low_reads_zero)
    else $error("low register mapping wrong");

  property p_timer_load;
    @(posedge clk_in) disable iff (!rst_n_in || !por_n_in)
    (src_reg == IDC_SRC_TIMER2 && timer_ovf_in[2]) |=> latch_reg == $past({high_reg, low_reg});
  endproperty
  a_timer_load: assert property (p_timer_load)
    else $error("timer2 no load");

  property p_por_clears_persist;
    @(posedge clk_in) !por_n_in |=> !persist_reg;
  endproperty
  a_por_clears_persist: assert property (p_por_clears_persist)
    else $error("por kept persist");

endmodule : idc_channel
`default_nettype wire

// >>> idc_core_model.sv
// idc_core_model: processor core side of the special function register bus
// assumes strobes are taken on the rising edge and read data stands one cycle later
`timescale 1ns/1ns
`default_nettype none
module idc_core_model
  import idc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       hit_in,
  output logic      [7:0] addr_out,
  output logic      [3:0] page_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic      [7:0] wdata_out
);
  initial
  begin
    addr_out  = 8'h00;
    page_out  = 4'h0;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 8'h00;
  end

  // one-cycle write strobe, fields held through the taking edge
  task automatic wr(input logic [3:0] page, input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_in);
    page_out  = page;
    addr_out  = addr;
    wdata_out = data;
    wr_out    = 1'b1;
    @(negedge clk_in);
    wr_out    = 1'b0;
    addr_out  = ~addr;
    wdata_out = ~data;
  endtask : wr

  // answer sampled while it stands, half a cycle after the taking edge
  task automatic rd(input logic [3:0] page, input logic [7:0] addr,
                    output logic [7:0] data, output logic hit);
    @(negedge clk_in);
    page_out = page;
    addr_out = addr;
    rd_out   = 1'b1;
    @(negedge clk_in);
    data     = rdata_in;
    hit      = hit_in;
    rd_out   = 1'b0;
    addr_out = ~addr;
  endtask : rd
endmodule : idc_core_model
`default_nettype wire

// >>> testbench.sv
// testbench: register, trigger and reset checks of the two-channel current dac
// assumes the core model drives the register bus at the falling clock edge
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("BAD %0t got %h exp %h", $time, got, exp); \
    end \
  end
module testbench
  import idc_pkg::*;
;
  logic       clk;
  logic       rst_n;
  logic       por_n;
  logic [7:0] addr;
  logic [3:0] page;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       hit;
  logic [5:0] tmr;
  logic       trig;
  logic [9:0] code0;
  logic [9:0] code1;
  logic       en0;
  logic       en1;
  logic [1:0] fs0;
  logic [1:0] fs1;
  int         fail_count = 0;
  int         cmp_count = 0;

  idc_dac_ctrl dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .POR_N_IN(por_n),
    .SFR_ADDR_IN(addr), .SFR_PAGE_IN(page), .SFR_WR_IN(wr), .SFR_RD_IN(rd),
    .SFR_WDATA_IN(wdata), .TIMER0_OVF_IN(tmr[0]), .TIMER1_OVF_IN(tmr[1]),
    .TIMER2_OVF_IN(tmr[2]), .TIMER3_OVF_IN(tmr[3]), .TIMER5_OVF_IN(tmr[5]),
    .EXTERNAL_CONVERSION_TRIGGER_IN(trig), .SFR_RDATA_OUT(rdata), .SFR_HIT_OUT(hit),
    .DAC0_CODE_OUT(code0), .DAC1_CODE_OUT(code1), .DAC0_ENABLE_OUT(en0),
    .DAC1_ENABLE_OUT(en1), .DAC0_FULLSCALE_OUT(fs0), .DAC1_FULLSCALE_OUT(fs1));

  idc_core_model core (.clk_in(clk), .rdata_in(rdata), .hit_in(hit), .addr_out(addr),
    .page_out(page), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  task automatic chk_rd(input logic [3:0] pg, input logic [7:0] a,
                        input logic [7:0] exp, input logic exp_hit);
    logic [7:0] d;
    logic       h;
    core.rd(pg, a, d, h);
    `CHK(d, exp)
    `CHK(h, exp_hit)
  endtask : chk_rd

  task automatic pulse(input logic [5:0] mask);
    @(negedge clk);
    tmr = mask;
    @(negedge clk);
    tmr = 6'h00;
  endtask : pulse

  task automatic edge_to(input logic a, input logic b);
    @(negedge clk);
    trig = a;
    @(negedge clk);
    trig = b;
  endtask : edge_to

  task automatic do_reset(input logic power_on);
    @(negedge clk);
    rst_n = 1'b0;
    por_n = ~power_on;
    settle(2);
    rst_n = 1'b1;
    por_n = 1'b1;
    settle(3);
  endtask : do_reset

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [3:0] pg;
    logic [7:0] hi;
    logic [9:0] old;
    int         idx;
    rst_n = 1'b0;
    por_n = 1'b0;
    tmr   = 6'h00;
    trig  = 1'b0;
    settle(16);
    rst_n = 1'b1;
    por_n = 1'b1;
    for (int ch = 0; ch < 2; ch++)
    begin
      pg = ch ? IDC_PAGE_CH1 : IDC_PAGE_CH0;
      chk_rd(pg, IDC_ADDR_CONTROL, 8'h72, 1'b1);
      chk_rd(pg, IDC_ADDR_WORD_HIGH, 8'h00, 1'b1);
      chk_rd(pg, IDC_ADDR_WORD_LOW, 8'h00, 1'b1);
    end
    `CHK(fs0, 2'h2)
    `CHK(en1, 1'b0)
    $display("test reset_values done");

    core.wr(IDC_PAGE_CH0, IDC_ADDR_WORD_LOW, 8'hFF);
    core.wr(IDC_PAGE_CH0, IDC_ADDR_WORD_HIGH, 8'hA5);
    core.wr(IDC_PAGE_CH1, IDC_ADDR_WORD_LOW, 8'h7F);
    core.wr(IDC_PAGE_CH1, IDC_ADDR_WORD_HIGH, 8'h3C);
    core.wr(IDC_PAGE_CH1, IDC_ADDR_CONTROL, 8'h7A);
    chk_rd(IDC_PAGE_CH0, IDC_ADDR_WORD_LOW, 8'hC0, 1'b1);
    chk_rd(IDC_PAGE_CH0, IDC_ADDR_WORD_HIGH, 8'hA5, 1'b1);
    chk_rd(IDC_PAGE_CH1, IDC_ADDR_CONTROL, 8'h72, 1'b1);
    chk_rd(4'h5, IDC_ADDR_WORD_HIGH, 8'h00, 1'b0);
    chk_rd(IDC_PAGE_CH0, 8'h55, 8'h00, 1'b0);
    settle(3);
    `CHK(code0, 10'h297)
    `CHK(code1, 10'h0F1)
    $display("test word_mapping done");

    for (int ch = 0; ch < 2; ch++)
      for (int code = 0; code < 7; code++)
      begin
        pg  = ch ? IDC_PAGE_CH1 : IDC_PAGE_CH0;
        hi  = 8'(8'h30 + 16 * code + ch);
        idx = (code > 3) ? 4 : ((ch == 1 && code == 1) ? 5 : code);
        old = ch ? code1 : code0;
        core.wr(pg, IDC_ADDR_CONTROL, {1'b1, code[2:0], 2'b00, code[1:0]});
        core.wr(pg, IDC_ADDR_WORD_LOW, 8'h7F);
        core.wr(pg, IDC_ADDR_WORD_HIGH, hi);
        pulse(6'h2F & ~(6'h01 << idx));
        settle(3);
        `CHK(ch ? code1 : code0, old)
        if (code < 4)
          pulse(6'h01 << idx);
        else if (code == 4)
          edge_to(1'b0, 1'b1);
        else if (code == 5)
          edge_to(1'b1, 1'b0);
        else
          edge_to(trig, ~trig);
        settle(3);
        `CHK(ch ? code1 : code0, {hi, 2'b01})
        `CHK(ch ? fs1 : fs0, code[1] ? 2'h2 : {1'b0, code[0]})
        `CHK(ch ? en1 : en0, 1'b1)
      end
    $display("test update_sources done");

    core.wr(IDC_PAGE_CH1, IDC_ADDR_CONTROL, 8'hF6);
    core.wr(IDC_PAGE_CH1, IDC_ADDR_CONTROL, 8'hF6);
    core.wr(IDC_PAGE_CH1, IDC_ADDR_WORD_LOW, 8'h80);
    core.wr(IDC_PAGE_CH1, IDC_ADDR_WORD_HIGH, 8'hC3);
    do_reset(1'b0);
    `CHK(en1, 1'b1)
    `CHK(code1, 10'h30E)
    `CHK(en0, 1'b0)
    `CHK(code0, 10'h000)
    `CHK(fs0, 2'h2)
    chk_rd(IDC_PAGE_CH1, IDC_ADDR_CONTROL, 8'hF6, 1'b1);
    chk_rd(IDC_PAGE_CH1, IDC_ADDR_WORD_HIGH, 8'hC3, 1'b1);
    chk_rd(IDC_PAGE_CH0, IDC_ADDR_WORD_HIGH, 8'h00, 1'b1);
    do_reset(1'b1);
    `CHK(en1, 1'b0)
    `CHK(code1, 10'h000)
    chk_rd(IDC_PAGE_CH1, IDC_ADDR_CONTROL, 8'h72, 1'b1);
    $display("test reset_persistence done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
